// ===== dv/test_ee_access_ctrl.sv
// Purpose: self-checking bench for the eeprom access controller
// Assumes: short write timer; bench drives every port 1 ns after the edge
// Notes:   expectations come from the register map, never from the dut

`timescale 1ns/1ps

module test_ee_access_ctrl;
	import ee_pkg::*;

	localparam int WC    = 8;
	localparam int LIMIT = 3000;

	logic         core_clk = 1'b0;
	logic         reset_n = 1'b0;
	ee_sfr_req_s  req = '0;
	logic [7:0]   sfr_rdata;
	logic         ext_reset_pin_n = 1'b1;
	logic         watchdog_reset = 1'b0;
	logic         code_protect = 1'b0;
	ee_prog_req_s preq = '0;
	logic [7:0]   prog_rdata;
	logic         write_busy;
	logic         write_done_irq;
	int           n_errors = 0;
	int           n_checks = 0;
	int           cyc = 0;

	always #10 core_clk = ~core_clk;

	ee_access_ctrl #(.WRITE_CYCLES(WC)) dut_u (
		.core_clk        (core_clk),
		.reset_n         (reset_n),
		.sfr_req         (req),
		.sfr_rdata       (sfr_rdata),
		.ext_reset_pin_n (ext_reset_pin_n),
		.watchdog_reset  (watchdog_reset),
		.code_protect    (code_protect),
		.prog_req        (preq),
		.prog_rdata      (prog_rdata),
		.write_busy      (write_busy),
		.write_done_irq  (write_done_irq)
	);

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_errors++;
			final_report();
		end
	end

	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask

	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		tick();
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		tick();
		req.wr = 1'b0;
	endtask

	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		tick();
		req.rd = 1'b1;
		req.addr = a;
		tick();
		d = sfr_rdata;
		req.rd = 1'b0;
	endtask

	task automatic prog_rd(input logic [5:0] a, output logic [7:0] d);
		tick();
		preq.en = 1'b1;
		preq.we = 1'b0;
		preq.addr = a;
		tick();
		d = prog_rdata;
		preq.en = 1'b0;
	endtask

	task automatic prog_wr(input logic [5:0] a, input logic [7:0] d);
		tick();
		preq.en = 1'b1;
		preq.we = 1'b1;
		preq.addr = a;
		preq.wdata = d;
		tick();
		preq.en = 1'b0;
		preq.we = 1'b0;
	endtask

	// read-start loads the data register, which is then read back
	task automatic cell_rd(input logic [7:0] a, output logic [7:0] d);
		sfr_wr(EE_ADDR_OFS, a);
		sfr_wr(EE_CTRL_OFS, 8'h01);
		sfr_rd(EE_DATA_OFS, d);
	endtask

	task automatic start_write();
		sfr_wr(EE_CTRL_OFS, 8'h04);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_FIRST);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_SECOND);
		sfr_wr(EE_CTRL_OFS, 8'h06);
	endtask

	task automatic reset_case();
		logic [7:0] d;
		sfr_rd(EE_CTRL_OFS, d);
		check(d, 8'h00);
		check(8'(write_busy), 8'h00);
		check(8'(write_done_irq), 8'h00);
		$display("test reset_case done");
	endtask

	task automatic write_case();
		logic [7:0] d;
		int         t0;
		sfr_wr(EE_DATA_OFS, 8'h5A);
		sfr_wr(EE_ADDR_OFS, 8'h05);
		start_write();
		t0 = cyc;
		check(8'(write_busy), 8'h01);
		prog_rd(6'h05, d);
		check(d, EE_ERASED);
		// clearing allow and start mid-write must not stop it
		sfr_wr(EE_CTRL_OFS, 8'h00);
		check(8'(write_busy), 8'h01);
		while (write_busy === 1'b1 && cyc - t0 < 50)
			tick();
		check(8'(cyc - t0), 8'(WC));
		check(8'(write_done_irq), 8'h01);
		sfr_rd(EE_CTRL_OFS, d);
		check(d, 8'h10);
		sfr_wr(EE_CTRL_OFS, 8'h00);
		check(8'(write_done_irq), 8'h00);
		cell_rd(8'h05, d);
		check(d, 8'h5A);
		$display("test write_case done");
	endtask

	task automatic refuse_case();
		logic [7:0] d;
		sfr_wr(EE_CTRL_OFS, 8'h04);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_FIRST);
		sfr_wr(EE_DATA_OFS, 8'h11);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_SECOND);
		sfr_wr(EE_CTRL_OFS, 8'h06);
		check(8'(write_busy), 8'h00);
		sfr_wr(EE_CTRL_OFS, 8'h00);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_FIRST);
		sfr_wr(EE_UNLOCK_OFS, EE_KEY_SECOND);
		sfr_wr(EE_CTRL_OFS, 8'h02);
		check(8'(write_busy), 8'h00);
		sfr_rd(EE_CTRL_OFS, d);
		check(d, 8'h00);
		sfr_rd(EE_UNLOCK_OFS, d);
		check(d, 8'h00);
		sfr_rd(8'h20, d);
		check(d, 8'h00);
		$display("test refuse_case done");
	endtask

	task automatic read_case();
		logic [7:0] d;
		code_protect = 1'b1;
		cell_rd(8'h05, d);
		check(d, 8'h5A);
		sfr_rd(EE_CTRL_OFS, d);
		check(d, 8'h00);
		sfr_rd(EE_DATA_OFS, d);
		check(d, 8'h5A);
		prog_rd(6'h05, d);
		check(d, 8'h00);
		prog_wr(6'h05, 8'h77);
		code_protect = 1'b0;
		prog_rd(6'h05, d);
		check(d, 8'h5A);
		prog_wr(6'h06, 8'h77);
		prog_rd(6'h06, d);
		check(d, 8'h77);
		// upper address bits set: outside the implemented cells
		cell_rd(8'h45, d);
		check(d, EE_ZERO);
		$display("test read_case done");
	endtask

	// pin path is synchronised, so it is held low longer than the watchdog
	task automatic abort_case(input logic use_pin);
		logic [7:0] d;
		sfr_wr(EE_DATA_OFS, 8'h3C);
		sfr_wr(EE_ADDR_OFS, 8'h07);
		start_write();
		if (use_pin)
			ext_reset_pin_n = 1'b0;
		else
			watchdog_reset = 1'b1;
		tick();
		watchdog_reset = 1'b0;
		repeat (2) tick();
		ext_reset_pin_n = 1'b1;
		repeat (3) tick();
		check(8'(write_busy), 8'h00);
		sfr_rd(EE_CTRL_OFS, d);
		check(d, 8'h08);
		sfr_rd(EE_DATA_OFS, d);
		check(d, 8'h3C);
		sfr_rd(EE_ADDR_OFS, d);
		check(d, 8'h07);
		sfr_wr(EE_CTRL_OFS, 8'h00);
		$display("test abort_case done");
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		reset_case();
		write_case();
		refuse_case();
		read_case();
		abort_case(1'b0);
		abort_case(1'b1);
		final_report();
	end

endmodule // test_ee_access_ctrl

// ===== src/ee_access_ctrl.sv
// Purpose: register-mapped access controller for a 64-byte data eeprom
// Assumes: reset_n is power-on reset; cpu reset events arrive separately
// Notes:   sfr reads answer one cycle after the read strobe
//
// Function
// - Byte data register and address register reach 64 bytes, 0h to 3Fh.
// - A byte write erases the location first, then stores the new value.
// - An internal timer sets write length; write ends when timer expires.
// - Code protection blocks programmer access but never cpu access.
// - Control register has five bits; bits 7:5 read zero.
// - Read-start launches a one-cycle read, self-clears; writing zero ignored.
// - Write-start runs until write finishes; software cannot clear it.
// - Write-allow permits writes when set; cleared at power-up.
// - Abort flag sets when external or watchdog reset cuts a write.
// - Data and address registers keep contents across an aborting reset.
// - Done flag sets when a write completes, held until software clears.
// - Unlock register has no storage, reads zero, only takes the sequence.
// - Write starts only after 55h, AAh to unlock, then write-start.
// - Write-start cannot be set unless write-allow is already set.
// - Read data is in the data register next cycle and stays.
// - Clearing write-allow during a write does not stop it.

`timescale 1ns/1ps

module ee_access_ctrl
	import ee_pkg::*;
#(
	parameter int WRITE_CYCLES = EE_WRITE_CYCLES,
	parameter int TIMER_W      = 24
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire ee_sfr_req_s  sfr_req,
	output logic        [7:0] sfr_rdata,
	input  wire logic         ext_reset_pin_n,
	input  wire logic         watchdog_reset,
	input  wire logic         code_protect,
	input  wire ee_prog_req_s prog_req,
	output logic        [7:0] prog_rdata,
	output logic              write_busy,
	output logic              write_done_irq
);

	localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(WRITE_CYCLES - 1);

	logic [7:0]           ee_data_reg;
	logic [7:0]           ee_addr_reg;
	logic                 rd_bit;
	logic                 wr_bit;
	logic                 write_allow;
	logic                 write_abort_flag;
	logic                 write_done_flag;
	ee_unlock_e           ul_state;
	ee_wstate_e           ws_state;
	logic [TIMER_W-1:0]   timer;
	logic [EE_MEM_AW-1:0] wr_addr;
	logic [7:0]           wr_data;
	logic                 wr_addr_ok;

	logic [7:0]           next_data;
	logic [7:0]           next_addr;
	logic                 next_rd;
	logic                 next_wr;
	logic                 next_allow;
	logic                 next_abort;
	logic                 next_done;
	ee_unlock_e           next_ul;
	ee_wstate_e           next_ws;
	logic [TIMER_W-1:0]   next_timer;
	logic [EE_MEM_AW-1:0] next_wr_addr;
	logic [7:0]           next_wr_data;
	logic                 next_wr_ok;
	logic [7:0]           next_sfr_rdata;
	logic [7:0]           next_prog_rdata;

	logic                 ext_sync1;
	logic                 ext_sync2;
	logic                 soft_rst;
	logic                 addr_ok;
	logic                 wr_ctrl;
	logic [7:0]           ctrl_view;
	logic                 mem_we;
	logic [EE_MEM_AW-1:0] mem_waddr;
	logic [7:0]           mem_wdata;
	logic [7:0]           cpu_cell;
	logic [7:0]           prog_cell;
	logic                 prog_ok;

	// pin reset passes two flops before anything looks at it
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ext_sync1 <= 1'b1;
			ext_sync2 <= 1'b1;
		end else begin
			ext_sync1 <= ext_reset_pin_n;
			ext_sync2 <= ext_sync1;
		end
	end

	assign soft_rst  = !ext_sync2 || watchdog_reset;
	assign addr_ok   = (ee_addr_reg[7:6] == 2'b00);
	assign wr_ctrl   = sfr_req.wr && (sfr_req.addr == EE_CTRL_OFS);
	assign ctrl_view = {3'b000, write_done_flag, write_abort_flag,
		write_allow, wr_bit, rd_bit};
	assign prog_ok   = prog_req.en && !code_protect;

	ee_store #(.BYTES(EE_MEM_BYTES), .AW(EE_MEM_AW)) u_store (
		.core_clk (core_clk),
		.we       (mem_we),
		.waddr    (mem_waddr),
		.wdata    (mem_wdata),
		.raddr_a  (ee_addr_reg[EE_MEM_AW-1:0]),
		.rdata_a  (cpu_cell),
		.raddr_b  (prog_req.addr),
		.rdata_b  (prog_cell)
	);

	always_comb begin
		next_data       = ee_data_reg;
		next_addr       = ee_addr_reg;
		next_rd         = 1'b0;
		next_wr         = wr_bit;
		next_allow      = write_allow;
		next_abort      = write_abort_flag;
		next_done       = write_done_flag;
		next_ul         = ul_state;
		next_ws         = ws_state;
		next_timer      = timer;
		next_wr_addr    = wr_addr;
		next_wr_data    = wr_data;
		next_wr_ok      = wr_addr_ok;
		next_sfr_rdata  = sfr_rdata;
		next_prog_rdata = prog_rdata;
		mem_we          = 1'b0;
		mem_waddr       = prog_req.addr;
		mem_wdata       = prog_req.wdata;

		if (sfr_req.rd) begin
			case (sfr_req.addr)
				EE_DATA_OFS: next_sfr_rdata = ee_data_reg;
				EE_ADDR_OFS: next_sfr_rdata = ee_addr_reg;
				EE_CTRL_OFS: next_sfr_rdata = ctrl_view;
				default:     next_sfr_rdata = EE_ZERO;
			endcase
		end

		if (sfr_req.wr && sfr_req.addr == EE_DATA_OFS) begin
			next_data = sfr_req.wdata;
		end
		if (sfr_req.wr && sfr_req.addr == EE_ADDR_OFS) begin
			next_addr = sfr_req.wdata;
		end

		// unlock keys must be the very last two sfr writes before start
		if (sfr_req.wr) begin
			next_ul = EE_UL_IDLE;
			if (sfr_req.addr == EE_UNLOCK_OFS) begin
				if (sfr_req.wdata == EE_KEY_FIRST) begin
					next_ul = EE_UL_FIRST;
				end else if (sfr_req.wdata == EE_KEY_SECOND &&
						ul_state == EE_UL_FIRST) begin
					next_ul = EE_UL_ARMED;
				end
			end
		end

		if (wr_ctrl) begin
			next_allow = sfr_req.wdata[EE_ALLOW_BIT];
			next_abort = sfr_req.wdata[EE_ABORT_BIT];
			next_done  = sfr_req.wdata[EE_DONE_BIT];
			if (sfr_req.wdata[EE_RD_BIT]) begin
				// read completes at this same edge
				next_rd   = 1'b1;
				next_data = addr_ok ? cpu_cell : EE_ZERO;
			end
			if (sfr_req.wdata[EE_WR_BIT] && write_allow &&
					ul_state == EE_UL_ARMED &&
					ws_state == EE_WS_IDLE && !soft_rst) begin
				next_wr      = 1'b1;
				next_ws      = EE_WS_BUSY;
				next_timer   = TIMER_LOAD;
				next_wr_addr = ee_addr_reg[EE_MEM_AW-1:0];
				next_wr_data = ee_data_reg;
				next_wr_ok   = addr_ok;
				mem_we       = addr_ok;
				mem_waddr    = ee_addr_reg[EE_MEM_AW-1:0];
				mem_wdata    = EE_ERASED;
			end
		end

		case (ws_state)
			EE_WS_IDLE: begin
				if (!mem_we && prog_ok && prog_req.we) begin
					mem_we = 1'b1;
				end
			end
			EE_WS_BUSY: begin
				if (timer == '0) begin
					next_wr   = 1'b0;
					next_ws   = EE_WS_IDLE;
					next_done = 1'b1;
					mem_we    = wr_addr_ok && !soft_rst;
					mem_waddr = wr_addr;
					mem_wdata = wr_data;
				end else begin
					next_timer = timer - 1'b1;
				end
			end
			default: next_ws = EE_WS_IDLE;
		endcase

		next_prog_rdata = prog_ok ? prog_cell : EE_ZERO;

		// cpu reset: data and address deliberately left untouched
		if (soft_rst) begin
			next_rd    = 1'b0;
			next_wr    = 1'b0;
			next_allow = 1'b0;
			next_ul    = EE_UL_IDLE;
			next_ws    = EE_WS_IDLE;
			next_data  = ee_data_reg;
			next_addr  = ee_addr_reg;
			if (ws_state == EE_WS_BUSY) begin
				next_abort = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			ee_data_reg      <= EE_BYTE_RST;
			ee_addr_reg      <= EE_BYTE_RST;
			rd_bit           <= 1'b0;
			wr_bit           <= 1'b0;
			write_allow      <= 1'b0;
			write_abort_flag <= 1'b0;
			write_done_flag  <= 1'b0;
			ul_state         <= EE_UL_IDLE;
			ws_state         <= EE_WS_IDLE;
			timer            <= '0;
			wr_addr          <= '0;
			wr_data          <= EE_BYTE_RST;
			wr_addr_ok       <= 1'b0;
			sfr_rdata        <= EE_ZERO;
			prog_rdata       <= EE_ZERO;
		end else begin
			ee_data_reg      <= next_data;
			ee_addr_reg      <= next_addr;
			rd_bit           <= next_rd;
			wr_bit           <= next_wr;
			write_allow      <= next_allow;
			write_abort_flag <= next_abort;
			write_done_flag  <= next_done;
			ul_state         <= next_ul;
			ws_state         <= next_ws;
			timer            <= next_timer;
			wr_addr          <= next_wr_addr;
			wr_data          <= next_wr_data;
			wr_addr_ok       <= next_wr_ok;
			sfr_rdata        <= next_sfr_rdata;
			prog_rdata       <= next_prog_rdata;
		end
	end

	assign write_busy     = wr_bit;
	assign write_done_irq = write_done_flag;

	a_ctrl_upper_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
		sfr_req.rd && sfr_req.addr == EE_CTRL_OFS |=> sfr_rdata[7:5] == 3'b000)
		else $error("control upper bits not zero");
	a_unlock_reads_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
		sfr_req.rd && sfr_req.addr == EE_UNLOCK_OFS |=> sfr_rdata == EE_ZERO)
		else $error("unlock register read nonzero");
	// a fresh read-start in the same cycle legally keeps the bit up
	a_read_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
		rd_bit && !(wr_ctrl && sfr_req.wdata[EE_RD_BIT]) |=> !rd_bit)
		else $error("read start bit held");
	a_read_data: assert property (@(posedge core_clk) disable iff (!reset_n)
		wr_ctrl && sfr_req.wdata[EE_RD_BIT] && addr_ok && !soft_rst
		|=> ee_data_reg == $past(cpu_cell) && rd_bit)
		else $error("read data not loaded next cycle");
	a_start_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(wr_bit) |-> $past(write_allow) && $past(ul_state) == EE_UL_ARMED
			&& $past(wr_ctrl))
		else $error("write started without unlock or allow");
	a_wr_no_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
		wr_bit && timer != '0 && !soft_rst |=> wr_bit && timer == $past(timer) - 1'b1)
		else $error("write cut short without reset");
	a_write_finish: assert property (@(posedge core_clk) disable iff (!reset_n)
		wr_bit && timer == '0 |=> !wr_bit && write_done_flag)
		else $error("write end did not set done");
	a_abort_flag: assert property (@(posedge core_clk) disable iff (!reset_n)
		wr_bit && soft_rst |=> write_abort_flag && !wr_bit)
		else $error("aborted write not flagged");
	a_regs_kept: assert property (@(posedge core_clk) disable iff (!reset_n)
		soft_rst |=> $stable(ee_data_reg) && $stable(ee_addr_reg))
		else $error("data or address lost on reset");
	a_prog_blocked: assert property (@(posedge core_clk) disable iff (!reset_n)
		code_protect |-> !(mem_we && ws_state == EE_WS_IDLE && !wr_ctrl))
		else $error("programmer wrote while protected");

endmodule // ee_access_ctrl

// ===== src/ee_pkg.sv
// Purpose: shared constants and types for the data eeprom access controller
// Assumes: 50 MHz core clock; byte-wide special function register port
// Notes:   offsets are byte addresses on the special function register port

package ee_pkg;

	localparam logic [7:0] EE_DATA_OFS   = 8'h08;
	localparam logic [7:0] EE_ADDR_OFS   = 8'h09;
	localparam logic [7:0] EE_CTRL_OFS   = 8'h88;
	localparam logic [7:0] EE_UNLOCK_OFS = 8'h89;

	localparam int EE_RD_BIT    = 0;
	localparam int EE_WR_BIT    = 1;
	localparam int EE_ALLOW_BIT = 2;
	localparam int EE_ABORT_BIT = 3;
	localparam int EE_DONE_BIT  = 4;

	localparam logic [7:0] EE_KEY_FIRST  = 8'h55;
	localparam logic [7:0] EE_KEY_SECOND = 8'hAA;
	localparam logic [7:0] EE_ERASED     = 8'hFF;
	localparam logic [7:0] EE_BYTE_RST   = 8'h00;
	localparam logic [7:0] EE_ZERO       = 8'h00;

	localparam int EE_MEM_BYTES = 64;
	localparam int EE_MEM_AW    = 6;

	localparam int EE_CLK_PERIOD_NS = 20;
	localparam int EE_WRITE_TIME_NS = 4000000;
	localparam int EE_WRITE_CYCLES  = EE_WRITE_TIME_NS / EE_CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		EE_UL_IDLE  = 2'b00,
		EE_UL_FIRST = 2'b01,
		EE_UL_ARMED = 2'b10
	} ee_unlock_e;

	typedef enum logic {
		EE_WS_IDLE = 1'b0,
		EE_WS_BUSY = 1'b1
	} ee_wstate_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ee_sfr_req_s;

	typedef struct packed {
		logic                 en;
		logic                 we;
		logic [EE_MEM_AW-1:0] addr;
		logic [7:0]           wdata;
	} ee_prog_req_s;

endpackage

// ===== src/ee_store.sv
// Purpose: byte array that stands in for the data eeprom cells
// Assumes: one write port, two asynchronous read ports
// Notes:   no reset; cell contents survive every reset like real cells

`timescale 1ns/1ps

module ee_store
	import ee_pkg::*;
#(
	parameter int BYTES = EE_MEM_BYTES,
	parameter int AW    = EE_MEM_AW
) (
	input  wire logic          core_clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	input  wire logic [AW-1:0] raddr_a,
	output logic      [7:0]    rdata_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic      [7:0]    rdata_b
);

	logic [7:0] cells [BYTES];

	always_ff @(posedge core_clk) begin
		if (we) begin
			cells[waddr] <= wdata;
		end
	end

	assign rdata_a = cells[raddr_a];
	assign rdata_b = cells[raddr_b];

endmodule // ee_store
